// >>> tb/aspt_asserts.sv
// checker: bus handshakes and line framing
// assumes bind to aspt_top
`timescale 1ns/1ps
module aspt_asserts (
  input wire CLK_IN,
  input wire RST_IN,
  input wire AXI_AWVALID_IN,
  input wire AXI_AWREADY_OUT,
  input wire AXI_WVALID_IN,
  input wire AXI_WREADY_OUT,
  input wire [1:0] AXI_BRESP_OUT,
  input wire AXI_BVALID_OUT,
  input wire AXI_BREADY_IN,
  input wire AXI_ARVALID_IN,
  input wire AXI_ARREADY_OUT,
  input wire [31:0] AXI_RDATA_OUT,
  input wire AXI_RVALID_OUT,
  input wire AXI_RREADY_IN,
  input wire FULL_PORT_SERIAL_OUT,
  input wire CONSOLE_SERIAL_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  sequence wr_taken;
    AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
  endsequence
  sequence start_low(s);
    !s [*8];
  endsequence
  AST_WR_ANSWER: assert property (wr_taken |-> ##[1:3] AXI_BVALID_OUT)
    else $error("no bvalid");
  AST_B_STANDS: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=>
    AXI_BVALID_OUT && $stable(AXI_BRESP_OUT)) else $error("bvalid dropped");
  AST_B_DONE: assert property (AXI_BVALID_OUT && AXI_BREADY_IN |=> !AXI_BVALID_OUT)
    else $error("bvalid held");
  AST_W_REFUSE: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT && !AXI_WREADY_OUT)
    else $error("ready while busy");
  AST_RD_ANSWER: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT |-> ##[1:3]
    AXI_RVALID_OUT) else $error("no rvalid");
  AST_R_STANDS: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=>
    AXI_RVALID_OUT && $stable(AXI_RDATA_OUT)) else $error("rdata moved");
  AST_R_UPPER: assert property (AXI_RVALID_OUT |->
    AXI_RDATA_OUT[31:16] == 16'h0000 && !AXI_ARREADY_OUT) else $error("read word bad");
  AST_FULL_START: assert property ($fell(FULL_PORT_SERIAL_OUT) |->
    start_low(FULL_PORT_SERIAL_OUT)) else $error("full low short");
  AST_CON_START: assert property ($fell(CONSOLE_SERIAL_OUT) |->
    start_low(CONSOLE_SERIAL_OUT)) else $error("console low short");
endmodule
bind aspt_top aspt_asserts u_chk (.*);

// >>> tb/aspt_modem.sv
// modem model: 8N1 receiver and sender
// assumes fixed bit time
`timescale 1ns/1ps
module aspt_modem #(
  parameter int BIT_NS = 320
) (
  input wire logic line_in,
  input wire logic ready_in,
  input wire logic ring_in,
  output logic line_out,
  output logic cts_n_out,
  output logic dsr_n_out,
  output logic dcd_n_out,
  output logic ri_n_out,
  output logic [7:0] got_out,
  output int got_cnt_out
);
  logic [7:0] sh;
  assign cts_n_out = !ready_in;
  assign dsr_n_out = 1'b0;
  assign dcd_n_out = 1'b0;
  assign ri_n_out = !ring_in;
  initial begin
    line_out = 1'b1;
    got_out = 8'h00;
    got_cnt_out = 0;
  end
  always begin
    @(negedge line_in);
    #(BIT_NS / 2);
    if (!line_in) begin
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        sh[i] = line_in;
      end
      #(BIT_NS);
      if (line_in) begin
        got_out = sh;
        got_cnt_out++;
      end
    end
  end
  task automatic send(input logic [7:0] d, input logic stop);
    line_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      line_out = d[i];
      #(BIT_NS);
    end
    line_out = stop;
    #(BIT_NS);
    line_out = 1'b1;
    #(BIT_NS);
  endtask
  task automatic glitch();
    line_out = 1'b0;
    #100;
    line_out = 1'b1;
  endtask
endmodule

// >>> tb/test_async_serial_port_trio.sv
// bench for the serial trio
// assumes modem on full port
`timescale 1ns/1ps
module test_async_serial_port_trio;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, rdy = 1, ring = 0;
  logic [7:0] awa = 0, ara = 0, got;
  logic [31:0] wd = 0, v;
  wire awr, wrr, bv, arr, rv, ftx, frx, ptx, ctx, rts_n, dtr_n, cts_n, dsr_n, ri_n, dcd_n;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [2:0] irq, dtx, drx;
  int bad_count = 0, samples_checked = 0, gcnt, c0;
  always #5 clk = ~clk;
  aspt_top u_dut (.CLK_IN(clk), .RST_IN(rst), .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv),
    .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'h3), .AXI_WVALID_IN(wv),
    .AXI_WREADY_OUT(wrr), .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(bre),
    .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rdat),
    .AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rre),
    .FULL_PORT_SERIAL_IN(frx), .FULL_PORT_SERIAL_OUT(ftx), .FULL_CLEAR_TO_SEND_N_IN(cts_n),
    .FULL_REQUEST_TO_SEND_N_OUT(rts_n), .FULL_DATA_SET_READY_N_IN(dsr_n),
    .FULL_DATA_TERMINAL_READY_N_OUT(dtr_n), .FULL_RING_INDICATE_N_IN(ri_n),
    .FULL_CARRIER_DETECT_N_IN(dcd_n), .PARTIAL_PORT_SERIAL_IN(1'b1),
    .PARTIAL_PORT_SERIAL_OUT(ptx), .PARTIAL_CLEAR_TO_SEND_N_IN(1'b0),
    .PARTIAL_REQUEST_TO_SEND_N_OUT(), .CONSOLE_SERIAL_IN(1'b1), .CONSOLE_SERIAL_OUT(ctx),
    .IRQ_OUT(irq), .DMA_TX_REQ_OUT(dtx), .DMA_RX_REQ_OUT(drx));
  aspt_modem u_modem (.line_in(ftx), .ready_in(rdy), .ring_in(ring), .line_out(frx),
    .cts_n_out(cts_n), .dsr_n_out(dsr_n), .dcd_n_out(dcd_n), .ri_n_out(ri_n),
    .got_out(got), .got_cnt_out(gcnt));
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 300) begin
      bad_count++;
      give_verdict();
    end
  endtask
  function automatic logic [1:0] rsp(input logic [7:0] a);
    return (a[7:6] == 2'h3 || a[5]) ? 2'h2 : 2'h0;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= {16'h0000, d};
    awv <= 1;
    wv <= 1;
    bre <= 1;
    n = 0;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrr) wv <= 0;
      n++;
    end while (!bv && n < 300);
    bre <= 0;
    chk("bresp", br, rsp(a));
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rre <= 1;
    n = 0;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
      n++;
    end while (!rv && n < 300);
    rre <= 0;
    v = rdat;
    chk("rresp", rr, rsp(a));
    tmo(n);
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while (!v[b] && n < 300);
    tmo(n);
  endtask
  task automatic wait_got();
    int n;
    for (n = 0; n < 300 && gcnt == c0; n++) repeat (10) @(posedge clk);
    tmo(n);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic t_reset();
    chk("idle pins", {rts_n, dtr_n, ftx, ptx, ctx}, 5'h1f);
    rd(8'h0C);
    chk("lcr", v, 32'h0000_0001);
    rd(8'h04);
    chk("ier", v, 32'h0000_0000);
    wr(8'h1C, 16'h9375);
    rd(8'h1C);
    chk("inc", v, 32'h0000_9375);
    wr(8'hC0, 16'h00FF);
    rd(8'h20);
    chk("unmapped", v, 32'h0000_0000);
  endtask
  task automatic t_loop();
    logic [7:0] b;
    for (int p = 0; p < 3; p++) begin
      b = {p[1:0], 6'h00};
      c0 = gcnt;
      wr(b | 8'h1C, 16'h8000);
      wr(b | 8'h10, 16'h0004);
      wr(b, 16'h00C0 + p);
      poll(b | 8'h14, 0);
      rd(b);
      chk("loop data", v, 32'h0000_00C0 + p);
      chk("loop leak", gcnt, c0);
      wr(b | 8'h10, 16'h0000);
    end
    wr(8'h80, 16'h0055);
  endtask
  task automatic t_tx();
    logic [23:0] tab [4] = '{24'h01_A5_A5, 24'h00_7F_FF, 24'h02_01_01, 24'h06_01_81};
    foreach (tab[i]) begin
      wr(8'h0C, {8'h00, tab[i][23:16]});
      c0 = gcnt;
      wr(8'h00, {8'h00, tab[i][15:8]});
      wait_got();
      chk("line char", got, tab[i][7:0]);
      poll(8'h14, 6);
      chk("tx idle", v[7:5], 3'h3);
    end
    wr(8'h0C, 16'h0001);
  endtask
  task automatic t_rx();
    u_modem.send(8'h5A, 1'b1);
    poll(8'h14, 0);
    rd(8'h00);
    chk("rx data", v, 32'h0000_005A);
    u_modem.glitch();
    repeat (100) @(posedge clk);
    rd(8'h14);
    chk("false start", v[0], 1'b0);
    u_modem.send(8'h00, 1'b0);
    poll(8'h14, 4);
    chk("break fe", v[3], 1'b1);
    rd(8'h00);
  endtask
  task automatic t_flow();
    wr(8'h10, 16'h0003);
    settle();
    chk("dtr", dtr_n, 1'b0);
    chk("rts", rts_n, 1'b0);
    rdy <= 0;
    wr(8'h10, 16'h0008);
    c0 = gcnt;
    wr(8'h00, 16'h0033);
    repeat (1000) @(posedge clk);
    chk("cts hold", gcnt, c0);
    rdy <= 1;
    wait_got();
    chk("cts go", got, 8'h33);
    for (int i = 0; i < 48; i++) begin
      if (i == 47) chk("rts low", rts_n, 1'b0);
      u_modem.send(i[7:0], 1'b1);
    end
    settle();
    chk("rts high", rts_n, 1'b1);
    for (int i = 0; i < 48; i++) begin
      rd(8'h00);
      chk("fifo order", v, i);
    end
    wr(8'h10, 16'h0000);
  endtask
  task automatic t_irq();
    wr(8'h04, 16'h0008);
    ring <= 1;
    for (int n = 0; n < 50 && irq[0] !== 1'b1; n++) @(posedge clk);
    rd(8'h08);
    chk("iir modem", v[3:0], 4'h0);
    wr(8'h04, 16'h000A);
    rd(8'h08);
    chk("iir prio", v[3:0], 4'h2);
    wr(8'h04, 16'h0000);
    rd(8'h18);
    ring <= 0;
    settle();
    chk("masked", irq[0], 1'b0);
    rd(8'h08);
    chk("iir none", v[3:0], 4'h1);
    wr(8'h04, 16'h0008);
    settle();
    chk("unmasked", irq[0], 1'b1);
    rd(8'h18);
    wr(8'h04, 16'h0010);
    settle();
    chk("dma tx", {dtx[0], drx[0]}, 2'h2);
    u_modem.send(8'h11, 1'b1);
    settle();
    chk("dma rx", drx[0], 1'b1);
    rd(8'h00);
    wr(8'h04, 16'h0000);
  endtask
  task automatic t_force();
    wr(8'h0C, 16'h0003);
    for (int k = 0; k < 2; k++) begin
      wr(8'h10, k ? 16'h0044 : 16'h0024);
      wr(8'h00, 16'h0055);
      poll(8'h14, k + 2);
      rd(8'h00);
    end
    wr(8'h10, 16'h0000);
    wr(8'h0C, 16'h0009);
    settle();
    chk("brk line", ftx, 1'b0);
    repeat (400) @(posedge clk);
    wr(8'h0C, 16'h0001);
    settle();
    chk("brk end", ftx, 1'b1);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_reset();
    t_loop();
    t_tx();
    t_rx();
    t_flow();
    t_irq();
    t_force();
    give_verdict();
  end
endmodule

// >>> verilog/aspt_consts.vh
// constants of the serial trio
// assumes include by top and engine
// Functional notes
// (R1) tx adds start, parity, stop bits; rx strips them
// (R2) 7 or 8 data bits, even, odd or no parity, one stop bit
// (R3) bit rate 9.6K to 3.6M bps on every port
// (R4) tx, rx, line and modem interrupts have own enables
// (R5) pending interrupt causes reported by fixed priority
// (R6) with auto-flow, request-to-send follows rx fifo level, no interrupt
// (R7) with auto-flow, clear-to-send gates the transmitter, no interrupt; cts change still sets msr delta, can interrupt
// (R8) send break on command; detect incoming break and report it
// (R9) loopback feeds transmitter output into receiver internally
// (R10) break, parity and framing errors can be forced for diagnostics
// (R11) start edge not low at mid-bit is dropped as false start
// (R12) separate tx and rx dma requests
// (R13) infrared mode with IrDA style pulse coding
// (R14) ring-indicate change can raise modem-status interrupt
// (R15) modem asserts clear-to-send low only when ready for data
// (R16) port drives request-to-send low when ready to send
// (R17) modem asserts data-set-ready low when ready for link
// (R18) full port drives data-terminal-ready low when ready
// (R19) modem asserts carrier-detect low on carrier
// (R20) full port has all modem lines, partial cts/rts, console none
// (R21) all three ports share features, rates and register model
// (R22) 64-entry tx and rx fifos; writes refused while tx full
// (R23) line idles at mark; one start bit; data lsb first
`ifndef ASPT_CONSTS_VH
`define ASPT_CONSTS_VH
`define ASPT_REG_DATA 3'h0
`define ASPT_REG_IER 3'h1
`define ASPT_REG_IIR 3'h2
`define ASPT_REG_LCR 3'h3
`define ASPT_REG_MCR 3'h4
`define ASPT_REG_LSR 3'h5
`define ASPT_REG_MSR 3'h6
`define ASPT_REG_INC 3'h7
`define ASPT_IER_RX 0
`define ASPT_IER_TX 1
`define ASPT_IER_LS 2
`define ASPT_IER_MS 3
`define ASPT_IER_DMA 4
`define ASPT_LCR_LEN8 0
`define ASPT_LCR_PEN 1
`define ASPT_LCR_EVEN 2
`define ASPT_LCR_BRK 3
`define ASPT_MCR_DTR 0
`define ASPT_MCR_RTS 1
`define ASPT_MCR_LOOP 2
`define ASPT_MCR_AFE 3
`define ASPT_MCR_IRDA 4
`define ASPT_MCR_FPE 5
`define ASPT_MCR_FFE 6
`define ASPT_MCR_FBRK 7
`define ASPT_LCR_RST 8'h01
`define ASPT_INC_RST 16'h04B8
`define ASPT_RTS_LEVEL 7'h30
`define ASPT_OVS_LAST 4'hF
`define ASPT_HALF_LAST 4'h7
`define ASPT_IR_PULSE 4'h3
`define ASPT_IID_NONE 4'h1
`define ASPT_IID_LS 4'h6
`define ASPT_IID_RX 4'h4
`define ASPT_IID_TX 4'h2
`define ASPT_IID_MS 4'h0
`define ASPT_RESP_OKAY 2'h0
`define ASPT_RESP_SLVERR 2'h2
`endif

// >>> verilog/aspt_engine.v
// serial engine: framing tx, oversampling rx
// assumes 16x tick and synchronised rx line
`timescale 1ns/1ps
`include "aspt_consts.vh"
module aspt_engine (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // line
  input wire tick_in,
  input wire rx_in,
  output reg tx_line_out,
  // mode
  input wire [7:0] lcr_in,
  input wire [7:0] mcr_in,
  input wire cts_ok_in,
  // transmit side
  input wire tx_valid_in,
  input wire [7:0] tx_data_in,
  output reg tx_pop_out,
  output reg tx_busy_out,
  // receive side
  output reg rx_valid_out,
  output reg [7:0] rx_data_out,
  output reg [2:0] rx_err_out
);
  localparam R_IDLE = 3'd0;
  localparam R_START = 3'd1;
  localparam R_BITS = 3'd2;
  localparam R_FIN = 3'd3;
  localparam R_WAIT = 3'd4;
  function par_of;
    input [7:0] d;
    input len8;
    input even;
    begin
      par_of = (len8 ? ^d : ^d[6:0]) ^ ~even;
    end
  endfunction
  wire len8 = lcr_in[`ASPT_LCR_LEN8];
  wire pen = lcr_in[`ASPT_LCR_PEN];
  wire peven = lcr_in[`ASPT_LCR_EVEN];
  wire brk = lcr_in[`ASPT_LCR_BRK] | mcr_in[`ASPT_MCR_FBRK]; // R8 R10
  wire loop = mcr_in[`ASPT_MCR_LOOP];
  wire irda = mcr_in[`ASPT_MCR_IRDA];
  wire pb = par_of(tx_data_in, len8, peven) ^ mcr_in[`ASPT_MCR_FPE]; // R10
  wire sb = ~mcr_in[`ASPT_MCR_FFE]; // R10
  wire [3:0] nbits = 4'd9 + {3'd0, len8} + {3'd0, pen}; // R2
  wire [3:0] nr = nbits - 4'd1;
  reg [9:0] rest;
  reg [10:0] tsh_q;
  reg [3:0] tleft_q;
  reg [3:0] tsub_q;
  reg istr_q;
  reg [3:0] ist_q;
  reg [2:0] rs_q;
  reg [3:0] rsub_q;
  reg [3:0] ridx_q;
  reg [9:0] rbuf_q;
  // frame body, lsb first
  always @* begin
    case ({len8, pen})
      2'b11: rest = {sb, pb, tx_data_in}; // R1 R2
      2'b10: rest = {1'b1, sb, tx_data_in};
      2'b01: rest = {1'b1, sb, pb, tx_data_in[6:0]};
      default: rest = {2'b11, sb, tx_data_in[6:0]};
    endcase
  end
  wire lvl = brk ? 1'b0 : (tx_busy_out ? tsh_q[0] : 1'b1); // R23
  wire rdec = irda ? ~istr_q : rx_in; // R13
  wire src = loop ? lvl : rdec; // R9
  wire [7:0] rdat = len8 ? rbuf_q[7:0] : {1'b0, rbuf_q[6:0]};
  wire rpb = len8 ? rbuf_q[8] : rbuf_q[7];
  wire rstop = rbuf_q[nr - 4'd1];
  // transmitter
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tsh_q <= 11'h7FF;
      tleft_q <= 4'd0;
      tsub_q <= 4'd0;
      tx_busy_out <= 1'b0;
      tx_pop_out <= 1'b0;
      tx_line_out <= 1'b1;
    end else begin
      tx_pop_out <= 1'b0;
      if (loop) begin
        tx_line_out <= ~irda; // R9
      end else if (irda) begin
        tx_line_out <= ~lvl & (tsub_q < `ASPT_IR_PULSE); // R13
      end else begin
        tx_line_out <= lvl;
      end
      if (tick_in) begin
        if (!tx_busy_out) begin
          tsub_q <= 4'd0;
          if (tx_valid_in && cts_ok_in) begin // R7
            tsh_q <= {rest, 1'b0}; // R1 R23
            tleft_q <= nbits;
            tx_busy_out <= 1'b1;
            tx_pop_out <= 1'b1;
          end
        end else begin
          tsub_q <= tsub_q + 4'd1;
          if (tsub_q == `ASPT_OVS_LAST) begin
            tsh_q <= {1'b1, tsh_q[10:1]};
            tleft_q <= tleft_q - 4'd1;
            if (tleft_q == 4'd1) begin
              tx_busy_out <= 1'b0;
            end
          end
        end
      end
    end
  end
  // infrared pulse stretcher
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      istr_q <= 1'b0;
      ist_q <= 4'd0;
    end else if (!rx_in) begin
      istr_q <= 1'b1; // R13
      ist_q <= 4'd0;
    end else if (tick_in && istr_q) begin
      ist_q <= ist_q + 4'd1;
      if (ist_q == `ASPT_OVS_LAST) begin
        istr_q <= 1'b0;
      end
    end
  end
  // receiver
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rs_q <= R_IDLE;
      rsub_q <= 4'd0;
      ridx_q <= 4'd0;
      rbuf_q <= 10'h000;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_err_out <= 3'h0;
    end else begin
      rx_valid_out <= 1'b0;
      case (rs_q)
        R_IDLE: begin
          if (tick_in && !src) begin
            rs_q <= R_START;
            rsub_q <= 4'd0;
          end
        end
        R_START: begin
          if (tick_in) begin
            rsub_q <= rsub_q + 4'd1;
            if (rsub_q == `ASPT_HALF_LAST) begin
              rsub_q <= 4'd0;
              ridx_q <= 4'd0;
              rbuf_q <= 10'h000;
              rs_q <= src ? R_IDLE : R_BITS; // R11
            end
          end
        end
        R_BITS: begin
          if (tick_in) begin
            rsub_q <= rsub_q + 4'd1;
            if (rsub_q == `ASPT_OVS_LAST) begin
              rbuf_q[ridx_q] <= src;
              ridx_q <= ridx_q + 4'd1;
              if (ridx_q == nr - 4'd1) begin
                rs_q <= R_FIN;
              end
            end
          end
        end
        R_FIN: begin
          rx_valid_out <= 1'b1;
          rx_data_out <= rdat; // R1
          rx_err_out <= {~|rbuf_q, ~rstop, pen & (rpb != par_of(rdat, len8, peven))}; // R8 R2
          rs_q <= R_WAIT;
        end
        R_WAIT: begin
          if (src) begin
            rs_q <= R_IDLE; // R8
          end
        end
        default: begin
          rs_q <= R_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> verilog/aspt_top.v
// three serial ports behind an AXI4-Lite slave
// assumes async pins; AXI master on CLK_IN
`timescale 1ns/1ps
`include "aspt_consts.vh"
module aspt_top (
  // clock and reset
  input wire CLK_IN,
  input wire RST_IN,
  // axi write address and data
  input wire [7:0] AXI_AWADDR_IN,
  input wire AXI_AWVALID_IN,
  output wire AXI_AWREADY_OUT,
  input wire [31:0] AXI_WDATA_IN,
  input wire [3:0] AXI_WSTRB_IN,
  input wire AXI_WVALID_IN,
  output wire AXI_WREADY_OUT,
  // axi write response
  output wire [1:0] AXI_BRESP_OUT,
  output wire AXI_BVALID_OUT,
  input wire AXI_BREADY_IN,
  // axi read
  input wire [7:0] AXI_ARADDR_IN,
  input wire AXI_ARVALID_IN,
  output wire AXI_ARREADY_OUT,
  output wire [31:0] AXI_RDATA_OUT,
  output wire [1:0] AXI_RRESP_OUT,
  output wire AXI_RVALID_OUT,
  input wire AXI_RREADY_IN,
  // full-function port
  input wire FULL_PORT_SERIAL_IN,
  output wire FULL_PORT_SERIAL_OUT,
  input wire FULL_CLEAR_TO_SEND_N_IN,
  output wire FULL_REQUEST_TO_SEND_N_OUT,
  input wire FULL_DATA_SET_READY_N_IN,
  output wire FULL_DATA_TERMINAL_READY_N_OUT,
  input wire FULL_RING_INDICATE_N_IN,
  input wire FULL_CARRIER_DETECT_N_IN,
  // partial-function port
  input wire PARTIAL_PORT_SERIAL_IN,
  output wire PARTIAL_PORT_SERIAL_OUT,
  input wire PARTIAL_CLEAR_TO_SEND_N_IN,
  output wire PARTIAL_REQUEST_TO_SEND_N_OUT,
  // console port
  input wire CONSOLE_SERIAL_IN,
  output wire CONSOLE_SERIAL_OUT,
  // per-port irq and dma, bit 0 full, 1 partial, 2 console
  output wire [2:0] IRQ_OUT,
  output wire [2:0] DMA_TX_REQ_OUT,
  output wire [2:0] DMA_RX_REQ_OUT
);
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[7:6] != 2'b11) & ~a[5];
    end
  endfunction
  reg awr_q;
  reg wrdy_q;
  reg aw_h_q;
  reg w_h_q;
  reg bv_q;
  reg [1:0] br_q;
  reg [7:0] aw_a_q;
  reg [15:0] w_d_q;
  reg [1:0] w_s_q;
  reg wr_q;
  reg arr_q;
  reg rd_q;
  reg rv_q;
  reg [7:0] ar_a_q;
  reg [31:0] rdat_q;
  reg [1:0] rr_q;
  wire [63:0] rd_all;
  wire [2:0] so_w;
  wire [2:0] rts_w;
  wire [2:0] dtr_w;
  wire [2:0] irq_w;
  wire [2:0] dtx_w;
  wire [2:0] drx_w;
  wire [2:0] rx_pin = {CONSOLE_SERIAL_IN, PARTIAL_PORT_SERIAL_IN, FULL_PORT_SERIAL_IN};
  // modem lines {dcd, ri, dsr, cts} per port, absent idle except console cts held low (asserted)
  wire [11:0] m_raw = {4'hE, 3'h7, PARTIAL_CLEAR_TO_SEND_N_IN,
    FULL_CARRIER_DETECT_N_IN, FULL_RING_INDICATE_N_IN,
    FULL_DATA_SET_READY_N_IN, FULL_CLEAR_TO_SEND_N_IN}; // R20 R17 R19
  assign rd_all[63:48] = 16'h0000;
  // axi write channel
  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      awr_q <= 1'b1;
      wrdy_q <= 1'b1;
      aw_h_q <= 1'b0;
      w_h_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= `ASPT_RESP_OKAY;
      aw_a_q <= 8'h00;
      w_d_q <= 16'h0000;
      w_s_q <= 2'b00;
      wr_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (AXI_AWVALID_IN && awr_q) begin
        aw_a_q <= AXI_AWADDR_IN;
        aw_h_q <= 1'b1;
        awr_q <= 1'b0;
      end
      if (AXI_WVALID_IN && wrdy_q) begin
        w_d_q <= AXI_WDATA_IN[15:0];
        w_s_q <= AXI_WSTRB_IN[1:0];
        w_h_q <= 1'b1;
        wrdy_q <= 1'b0;
      end
      if (aw_h_q && w_h_q && !bv_q) begin
        wr_q <= 1'b1;
        bv_q <= 1'b1;
        aw_h_q <= 1'b0;
        w_h_q <= 1'b0;
        br_q <= mapped(aw_a_q) ? `ASPT_RESP_OKAY : `ASPT_RESP_SLVERR;
      end
      if (bv_q && AXI_BREADY_IN) begin
        bv_q <= 1'b0;
        awr_q <= 1'b1;
        wrdy_q <= 1'b1;
      end
    end
  end
  // axi read channel
  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      arr_q <= 1'b1;
      rd_q <= 1'b0;
      rv_q <= 1'b0;
      ar_a_q <= 8'h00;
      rdat_q <= 32'h0000_0000;
      rr_q <= `ASPT_RESP_OKAY;
    end else begin
      rd_q <= 1'b0;
      if (AXI_ARVALID_IN && arr_q) begin
        ar_a_q <= AXI_ARADDR_IN;
        arr_q <= 1'b0;
        rd_q <= 1'b1;
      end
      if (rd_q) begin
        rv_q <= 1'b1;
        if (mapped(ar_a_q)) begin
          rdat_q <= {16'h0000, rd_all[ar_a_q[7:6] * 16 +: 16]};
          rr_q <= `ASPT_RESP_OKAY;
        end else begin
          rdat_q <= 32'h0000_0000;
          rr_q <= `ASPT_RESP_SLVERR;
        end
      end
      if (rv_q && AXI_RREADY_IN) begin
        rv_q <= 1'b0;
        arr_q <= 1'b1;
      end
    end
  end
  // one identical port per instance
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_port // R21
      localparam [1:0] PI = p;
      reg [7:0] ier_q;
      reg [7:0] lcr_q;
      reg [7:0] mcr_q;
      reg [15:0] inc_q;
      reg [15:0] acc_q;
      reg tick_q;
      reg [3:0] ls_q;
      reg [3:0] md_q;
      reg [3:0] mp_q;
      reg [1:0] rxs_q;
      reg [3:0] ms1_q;
      reg [3:0] ms2_q;
      reg [7:0] txm [0:63];
      reg [7:0] rxm [0:63];
      reg [6:0] twp_q;
      reg [6:0] trp_q;
      reg [6:0] rwp_q;
      reg [6:0] rrp_q;
      reg rts_n_q;
      reg dtr_n_q;
      reg irq_q;
      reg dtx_q;
      reg drx_q;
      reg [15:0] rv16;
      wire tpop;
      wire tbusy;
      wire rvld;
      wire [7:0] rdat8;
      wire [2:0] rerr;
      wire wsel = wr_q & (aw_a_q[7:6] == PI) & ~aw_a_q[5];
      wire [2:0] widx = aw_a_q[4:2];
      wire rsel = rd_q & (ar_a_q[7:6] == PI) & ~ar_a_q[5];
      wire [2:0] ridx = ar_a_q[4:2];
      wire [6:0] tcnt = twp_q - trp_q;
      wire [6:0] rcnt = rwp_q - rrp_q;
      wire tfull = tcnt[6];
      wire tempty = (tcnt == 7'd0);
      wire rfull = rcnt[6];
      wire rempty = (rcnt == 7'd0);
      wire [3:0] mcur = ~ms2_q;
      wire push = wsel & (widx == `ASPT_REG_DATA) & w_s_q[0] & ~tfull; // R22
      wire pop = rsel & (ridx == `ASPT_REG_DATA) & ~rempty;
      wire ovr = rvld & rfull;
      wire [3:0] lset = {rerr & {3{rvld}}, ovr}; // R8
      wire [3:0] mset = mcur ^ mp_q; // R14
      wire s_ls = ier_q[`ASPT_IER_LS] & |ls_q; // R4
      wire s_rx = ier_q[`ASPT_IER_RX] & ~rempty; // R4
      wire s_tx = ier_q[`ASPT_IER_TX] & tempty; // R4
      wire s_ms = ier_q[`ASPT_IER_MS] & |md_q; // R4 R14
      wire [3:0] iid = s_ls ? `ASPT_IID_LS : s_rx ? `ASPT_IID_RX :
        s_tx ? `ASPT_IID_TX : s_ms ? `ASPT_IID_MS : `ASPT_IID_NONE; // R5
      wire cts_ok = ~mcr_q[`ASPT_MCR_AFE] | mcur[0]; // R7 R15
      always @* begin
        case (ridx)
          `ASPT_REG_DATA: rv16 = {8'h00, rxm[rrp_q[5:0]]};
          `ASPT_REG_IER: rv16 = {8'h00, ier_q};
          `ASPT_REG_IIR: rv16 = {12'h000, iid};
          `ASPT_REG_LCR: rv16 = {8'h00, lcr_q};
          `ASPT_REG_MCR: rv16 = {8'h00, mcr_q};
          `ASPT_REG_LSR: rv16 = {8'h00, tfull, tempty & ~tbusy, tempty, ls_q, ~rempty};
          `ASPT_REG_MSR: rv16 = {8'h00, mcur, md_q};
          default: rv16 = inc_q;
        endcase
      end
      assign rd_all[16 * p +: 16] = rv16;
      // fifo storage
      always @(posedge CLK_IN) begin
        if (push) begin
          txm[twp_q[5:0]] <= w_d_q[7:0]; // R22
        end
        if (rvld && !rfull) begin
          rxm[rwp_q[5:0]] <= rdat8; // R22
        end
      end
      always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          ier_q <= 8'h00;
          lcr_q <= `ASPT_LCR_RST;
          mcr_q <= 8'h00;
          inc_q <= `ASPT_INC_RST;
          acc_q <= 16'h0000;
          tick_q <= 1'b0;
          ls_q <= 4'h0;
          md_q <= 4'h0;
          mp_q <= 4'h0;
          rxs_q <= 2'b11;
          ms1_q <= 4'hF;
          ms2_q <= 4'hF;
          twp_q <= 7'd0;
          trp_q <= 7'd0;
          rwp_q <= 7'd0;
          rrp_q <= 7'd0;
          rts_n_q <= 1'b1;
          dtr_n_q <= 1'b1;
          irq_q <= 1'b0;
          dtx_q <= 1'b0;
          drx_q <= 1'b0;
        end else begin
          {tick_q, acc_q} <= {1'b0, acc_q} + {1'b0, inc_q}; // R3
          rxs_q <= {rxs_q[0], rx_pin[p]};
          ms1_q <= m_raw[4 * p +: 4];
          ms2_q <= ms1_q;
          mp_q <= mcur;
          if (wsel && w_s_q[0]) begin
            case (widx)
              `ASPT_REG_IER: ier_q <= w_d_q[7:0];
              `ASPT_REG_LCR: lcr_q <= w_d_q[7:0]; // R2 R8
              `ASPT_REG_MCR: mcr_q <= w_d_q[7:0]; // R9 R10 R13
              `ASPT_REG_INC: inc_q[7:0] <= w_d_q[7:0];
              default: ;
            endcase
          end
          if (wsel && w_s_q[1] && widx == `ASPT_REG_INC) begin
            inc_q[15:8] <= w_d_q[15:8];
          end
          if (push) begin
            twp_q <= twp_q + 7'd1;
          end
          if (tpop) begin
            trp_q <= trp_q + 7'd1;
          end
          if (rvld && !rfull) begin
            rwp_q <= rwp_q + 7'd1;
          end
          if (pop) begin
            rrp_q <= rrp_q + 7'd1;
          end
          ls_q <= (ls_q & ~{4{rsel & (ridx == `ASPT_REG_LSR)}}) | lset;
          md_q <= (md_q & ~{4{rsel & (ridx == `ASPT_REG_MSR)}}) | mset; // R14
          if (mcr_q[`ASPT_MCR_AFE]) begin
            rts_n_q <= ~(rcnt < `ASPT_RTS_LEVEL); // R6 R16
          end else begin
            rts_n_q <= ~mcr_q[`ASPT_MCR_RTS]; // R16
          end
          dtr_n_q <= ~mcr_q[`ASPT_MCR_DTR]; // R18
          irq_q <= s_ls | s_rx | s_tx | s_ms; // R5
          dtx_q <= ier_q[`ASPT_IER_DMA] & ~tfull; // R12
          drx_q <= ier_q[`ASPT_IER_DMA] & ~rempty; // R12
        end
      end
      aspt_engine u_eng (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .tick_in(tick_q),
        .rx_in(rxs_q[1]),
        .tx_line_out(so_w[p]),
        .lcr_in(lcr_q),
        .mcr_in(mcr_q),
        .cts_ok_in(cts_ok),
        .tx_valid_in(~tempty),
        .tx_data_in(txm[trp_q[5:0]]),
        .tx_pop_out(tpop),
        .tx_busy_out(tbusy),
        .rx_valid_out(rvld),
        .rx_data_out(rdat8),
        .rx_err_out(rerr)
      );
      assign rts_w[p] = rts_n_q;
      assign dtr_w[p] = dtr_n_q;
      assign irq_w[p] = irq_q;
      assign dtx_w[p] = dtx_q;
      assign drx_w[p] = drx_q;
    end
  endgenerate
  // pin and bus outputs
  assign AXI_AWREADY_OUT = awr_q;
  assign AXI_WREADY_OUT = wrdy_q;
  assign AXI_BRESP_OUT = br_q;
  assign AXI_BVALID_OUT = bv_q;
  assign AXI_ARREADY_OUT = arr_q;
  assign AXI_RDATA_OUT = rdat_q;
  assign AXI_RRESP_OUT = rr_q;
  assign AXI_RVALID_OUT = rv_q;
  assign FULL_PORT_SERIAL_OUT = so_w[0];
  assign PARTIAL_PORT_SERIAL_OUT = so_w[1];
  assign CONSOLE_SERIAL_OUT = so_w[2];
  assign FULL_REQUEST_TO_SEND_N_OUT = rts_w[0]; // R20
  assign PARTIAL_REQUEST_TO_SEND_N_OUT = rts_w[1]; // R20
  assign FULL_DATA_TERMINAL_READY_N_OUT = dtr_w[0]; // R18 R20
  assign IRQ_OUT = irq_w;
  assign DMA_TX_REQ_OUT = dtx_w;
  assign DMA_RX_REQ_OUT = drx_w;
endmodule
